/* verilog/io_cond_regs.svh */
`ifndef IO_COND_REGS_SVH
`define IO_COND_REGS_SVH

// Register word indices (byte address = index * 4)
`define REG_ANALOG_CTRL      4'h0
`define REG_ANALOG_LOW       4'h1
`define REG_ANALOG_ZERO      4'h2
`define REG_ANALOG_HIGH      4'h3
`define REG_ANALOG_DEAD      4'h4
`define REG_ANALOG_LOW_ACT   4'h5
`define REG_DIN_LEVELS       4'h6
`define REG_OUT_LEVELS       4'h7
`define REG_DIN_ACTION       4'h8
`define REG_OUT_SOURCE       4'h9
`define REG_PULSE_ZERO       4'hA
`define REG_PULSE_CTRL       4'hB
`define REG_VALUES           4'hC
`define REG_STATUS           4'hD
`define NUM_CFG              4'hC
`define NUM_REGS             4'hE

// Reset values
`define RST_ANALOG_LOW       32'h0000_0064
`define RST_ANALOG_ZERO      32'h0000_09C4
`define RST_ANALOG_HIGH      32'h0000_1324
`define RST_DEAD_ZONE        32'h0000_0005
`define RST_PULSE_ZERO       32'h0000_05DC
`define RST_ZERO             32'h0000_0000

// Writable bits per register
`define MASK_ANALOG_CTRL     32'h0000_0313
`define MASK_U16             32'h0000_FFFF
`define MASK_U8              32'h0000_00FF
`define MASK_PULSE_CTRL      32'h0000_03FF
`define MASK_ALL             32'hFFFF_FFFF

// Field positions
`define F_MODE_LSB           0
`define F_INVERT             4
`define F_USE_LSB            8
`define F_STATUS_OUT_LSB     8
`define F_STATUS_LOW_HIT     16

// Conversion figures
`define FULL_SCALE           1000
`define REF_MV               5000
`define PCT_TO_SCALE         10
`define DEAD_MAX_PCT         50
`define LOW_DEAD_FROM_MV     5200
`define LOW_DEAD_TO_MV       10000
`define PULSE_LOW_US         1000
`define PULSE_HIGH_US        2000

`endif

/* verilog/io_cond_pkg.sv */
package io_cond_pkg;

    typedef enum logic [1:0] {
        MODE_DISABLED,
        MODE_ABSOLUTE,
        MODE_RELATIVE
    } analog_mode_t;

    typedef enum logic [1:0] {
        USE_NONE,
        USE_COMMAND,
        USE_FEEDBACK
    } input_use_t;

    typedef enum logic [3:0] {
        ACT_NONE,
        ACT_SAFETY_STOP,
        ACT_EMERGENCY_STOP,
        ACT_MOTOR_STOP,
        ACT_FWD_LIMIT,
        ACT_REV_LIMIT,
        ACT_INVERT_DIR,
        ACT_RUN_SCRIPT,
        ACT_LOAD_HOME
    } action_t;

    typedef enum logic [3:0] {
        SRC_NEVER,
        SRC_MOTOR_ON,
        SRC_MOTOR_REVERSED,
        SRC_OVERVOLTAGE,
        SRC_OVERTEMP,
        SRC_STATUS_LED,
        SRC_NO_SWITCH_FAIL
    } trigger_t;

    localparam int NUM_DIN    = 4;
    localparam int NUM_DOUT   = 4;
    localparam int NUM_MOTORS = 3;
    localparam int NUM_ACTS   = 8;

endpackage

/* verilog/io_conditioning.sv */
// Functional notes
// - Enabled analog input converts to signed -1000..0..+1000 from min/center/max points.
// - Analog low point: unsigned 16-bit millivolts, default 100, maps to lowest value.
// - Low point from 5200 to 10000 mV forces the analog result to zero.
// - Input at its low point fires the selected low action; default none.
// - Action codes: none, safety, emergency, motor stop, limits, invert, script, home.
// - Motor term added to action code: 16 motor one, 32 two, 48 three.
// - Analog mode: 0 disabled, 1 absolute 0-5 V, 2 relative to own 5 V.
// - Invert bit set flips converted value to +1000..-1000; default not inverted.
// - Active digital input fires its configured action on the encoded motors.
// - Input active levels: 32-bit, bit per input, 1 active low, default high.
// - Output source codes: never, motor on, reversed, overvolt, overtemp, LED, no fail.
// - Output levels: 32-bit, bit per output, 1 means off when active.
// - Pulse zero point in microseconds, default 1500, converts to zero.
// - Pulse dead zone 0 to 50 percent, default 5, zero span around center.
// - Dead zone skipped for inputs used as feedback.
// - Analog zero point, default 2500 mV, converts to zero.
// - Analog high point, default 4900 mV, converts to the highest value.
// - Analog dead zone 0 to 50 percent converts center movement to zero.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "io_cond_regs.svh"

module io_conditioning
    import io_cond_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          ce,
    // AXI4-Lite write
    input  wire logic [5:0]                    awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // AXI4-Lite read
    input  wire logic [5:0]                    araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Measurements
    input  wire logic [15:0]                   analog_mv,
    input  wire logic [15:0]                   supply_mv,
    input  wire logic [15:0]                   pulse_us,
    // Digital inputs and outputs
    input  wire logic [NUM_DIN-1:0]            din,
    output logic      [NUM_DOUT-1:0]           dout,
    // Motor and fault conditions
    input  wire logic [NUM_MOTORS-1:0]         motor_on,
    input  wire logic [NUM_MOTORS-1:0]         motor_reversed,
    input  wire logic                          overvoltage,
    input  wire logic                          overtemp,
    input  wire logic                          status_led,
    input  wire logic                          switch_fail,
    // Conditioned values and action requests
    output logic signed [11:0]                 analog_value,
    output logic signed [11:0]                 pulse_value,
    output logic [NUM_MOTORS*NUM_ACTS-1:0]     action_req
);

    logic [31:0]                    cfg [`NUM_CFG];
    logic [31:0]                    next_cfg [`NUM_CFG];
    logic                           bvalid_q;
    logic                           next_bvalid;
    logic [1:0]                     bresp_q;
    logic [1:0]                     next_bresp;
    logic                           rvalid_q;
    logic                           next_rvalid;
    logic [1:0]                     rresp_q;
    logic [1:0]                     next_rresp;
    logic [31:0]                    rdata_q;
    logic [31:0]                    next_rdata;
    logic [NUM_DIN-1:0]             din_meta;
    logic [NUM_DIN-1:0]             din_sync;
    logic [NUM_DOUT-1:0]            next_dout;
    logic signed [11:0]             next_analog;
    logic signed [11:0]             next_pulse;
    logic [NUM_MOTORS*NUM_ACTS-1:0] next_action;
    logic                           low_hit;
    logic                           next_low_hit;

    function automatic logic [31:0] reset_value(input int idx);
        case (idx)
            `REG_ANALOG_LOW:  reset_value = `RST_ANALOG_LOW;
            `REG_ANALOG_ZERO: reset_value = `RST_ANALOG_ZERO;
            `REG_ANALOG_HIGH: reset_value = `RST_ANALOG_HIGH;
            `REG_ANALOG_DEAD: reset_value = `RST_DEAD_ZONE;
            `REG_PULSE_ZERO:  reset_value = `RST_PULSE_ZERO;
            `REG_PULSE_CTRL:  reset_value = `RST_DEAD_ZONE;
            default:          reset_value = `RST_ZERO;
        endcase
    endfunction

    function automatic logic [31:0] write_mask(input int idx);
        case (idx)
            `REG_ANALOG_CTRL:                    write_mask = `MASK_ANALOG_CTRL;
            `REG_ANALOG_DEAD, `REG_ANALOG_LOW_ACT: write_mask = `MASK_U8;
            `REG_DIN_LEVELS, `REG_OUT_LEVELS,
            `REG_DIN_ACTION, `REG_OUT_SOURCE:    write_mask = `MASK_ALL;
            `REG_PULSE_CTRL:                     write_mask = `MASK_PULSE_CTRL;
            default:                             write_mask = `MASK_U16;
        endcase
    endfunction

    // Piecewise linear map, saturating outside the span
    function automatic int scale(input int x, input int lo, input int ctr, input int hi);
        int v;
        v = 0;
        if (x > ctr) begin
            if (x >= hi || hi <= ctr) begin
                v = `FULL_SCALE;
            end else begin
                v = ((x - ctr) * `FULL_SCALE) / (hi - ctr);
            end
        end else if (x < ctr && ctr > lo) begin
            if (x <= lo) begin
                v = -`FULL_SCALE;
            end else begin
                v = ((x - ctr) * `FULL_SCALE) / (ctr - lo);
            end
        end
        scale = v;
    endfunction

    // Zero inside the dead zone unless used as feedback, then optional inversion
    function automatic int shape(input int v, input int pct, input logic [1:0] use_sel,
                                 input logic inv);
        int lim;
        int r;
        lim = ((pct > `DEAD_MAX_PCT) ? `DEAD_MAX_PCT : pct) * `PCT_TO_SCALE;
        r = v;
        if (use_sel != USE_FEEDBACK && v < lim && v > -lim) begin
            r = 0;
        end
        shape = inv ? -r : r;
    endfunction

    // Adds one source's action onto the per-motor request vector
    function automatic logic [NUM_MOTORS*NUM_ACTS-1:0] decode_action(input logic [7:0] code,
                                                                     input logic active);
        logic [NUM_MOTORS*NUM_ACTS-1:0] req;
        logic [3:0]                     act;
        logic [3:0]                     mot;
        req = '0;
        act = code[3:0];
        mot = code[7:4];
        if (active && act != ACT_NONE && act <= ACT_LOAD_HOME) begin
            for (int m = 0; m < NUM_MOTORS; m++) begin
                if (mot == 4'h0 || int'(mot) == m + 1) begin
                    req[m*NUM_ACTS + int'(act) - 1] = 1'b1;
                end
            end
        end
        decode_action = req;
    endfunction

    // Register bus
    assign awready = ce && awvalid && wvalid && !bvalid_q;
    assign wready  = awready;
    assign arready = ce && arvalid && !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    always_comb begin
        logic [3:0]  widx;
        logic [3:0]  ridx;
        logic [31:0] wmask;
        widx        = awaddr[5:2];
        ridx        = araddr[5:2];
        wmask       = write_mask(int'(widx));
        next_cfg    = cfg;
        next_bvalid = bvalid_q && !bready;
        next_bresp  = bresp_q;
        next_rvalid = rvalid_q && !rready;
        next_rresp  = rresp_q;
        next_rdata  = rdata_q;
        if (awready) begin
            next_bvalid = 1'b1;
            next_bresp  = 2'b10;
            if (widx < `NUM_CFG) begin
                next_bresp = 2'b00;
                for (int b = 0; b < 4; b++) begin
                    if (wstrb[b]) begin
                        next_cfg[widx][b*8 +: 8] = wdata[b*8 +: 8] & wmask[b*8 +: 8];
                    end
                end
            end
        end
        if (arready) begin
            next_rvalid = 1'b1;
            next_rresp  = 2'b00;
            next_rdata  = 32'h0000_0000;
            if (ridx < `NUM_CFG) begin
                next_rdata = cfg[ridx];
            end else if (ridx == `REG_VALUES) begin
                next_rdata = {16'(pulse_value), 16'(analog_value)};
            end else if (ridx == `REG_STATUS) begin
                next_rdata = {15'h0000, low_hit, 4'h0, dout, 4'h0, din_sync};
            end else begin
                next_rresp = 2'b10;
            end
        end
    end

    // Conditioning and actions
    always_comb begin
        int             x;
        int             low;
        int             v;
        logic [1:0]     mode;
        logic [NUM_DIN-1:0] din_active;
        logic           cond;
        logic [7:0]     src;
        cond       = 1'b0;
        src        = 8'h00;
        din_active = '0;
        mode = cfg[`REG_ANALOG_CTRL][`F_MODE_LSB +: 2];
        low  = int'(cfg[`REG_ANALOG_LOW][15:0]);
        x    = int'(analog_mv);
        if (mode == MODE_RELATIVE) begin
            x = (supply_mv == 16'h0000) ? 0 : (int'(analog_mv) * `REF_MV) / int'(supply_mv);
        end
        v = scale(x, low, int'(cfg[`REG_ANALOG_ZERO][15:0]), int'(cfg[`REG_ANALOG_HIGH][15:0]));
        v = shape(v, int'(cfg[`REG_ANALOG_DEAD][7:0]), cfg[`REG_ANALOG_CTRL][`F_USE_LSB +: 2],
                  cfg[`REG_ANALOG_CTRL][`F_INVERT]);
        if (mode == MODE_DISABLED || mode > MODE_RELATIVE) begin
            v = 0;
        end
        if (low >= `LOW_DEAD_FROM_MV && low <= `LOW_DEAD_TO_MV) begin
            v = 0;
        end
        next_analog  = 12'(v);
        next_low_hit = (mode == MODE_ABSOLUTE || mode == MODE_RELATIVE) && x <= low;
        v = scale(int'(pulse_us), `PULSE_LOW_US, int'(cfg[`REG_PULSE_ZERO][15:0]), `PULSE_HIGH_US);
        next_pulse = 12'(shape(v, int'(cfg[`REG_PULSE_CTRL][7:0]), cfg[`REG_PULSE_CTRL][`F_USE_LSB +: 2], 1'b0));
        next_action = decode_action(cfg[`REG_ANALOG_LOW_ACT][7:0], next_low_hit);
        din_active  = din_sync ^ cfg[`REG_DIN_LEVELS][NUM_DIN-1:0];
        for (int i = 0; i < NUM_DIN; i++) begin
            next_action = next_action | decode_action(cfg[`REG_DIN_ACTION][i*8 +: 8], din_active[i]);
        end
        for (int o = 0; o < NUM_DOUT; o++) begin
            src = cfg[`REG_OUT_SOURCE][o*8 +: 8];
            case (src[3:0])
                SRC_MOTOR_ON:       cond = |(motor_on & ((src[7:4] == 4'h0) ? 3'h7 : 3'(1 << (src[7:4] - 1))));
                SRC_MOTOR_REVERSED: cond = |(motor_reversed & ((src[7:4] == 4'h0) ? 3'h7 : 3'(1 << (src[7:4] - 1))));
                SRC_OVERVOLTAGE:    cond = overvoltage;
                SRC_OVERTEMP:       cond = overtemp;
                SRC_STATUS_LED:     cond = status_led;
                SRC_NO_SWITCH_FAIL: cond = !switch_fail;
                default:            cond = 1'b0;
            endcase
            next_dout[o] = cond ^ cfg[`REG_OUT_LEVELS][o];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `NUM_CFG; i++) begin
                cfg[i] <= reset_value(i);
            end
            bvalid_q     <= 1'b0;
            bresp_q      <= 2'b00;
            rvalid_q     <= 1'b0;
            rresp_q      <= 2'b00;
            rdata_q      <= 32'h0000_0000;
            din_meta     <= '0;
            din_sync     <= '0;
            dout         <= '0;
            analog_value <= '0;
            pulse_value  <= '0;
            action_req   <= '0;
            low_hit      <= 1'b0;
        end else if (ce) begin
            cfg          <= next_cfg;
            bvalid_q     <= next_bvalid;
            bresp_q      <= next_bresp;
            rvalid_q     <= next_rvalid;
            rresp_q      <= next_rresp;
            rdata_q      <= next_rdata;
            din_meta     <= din;
            din_sync     <= din_meta;
            dout         <= next_dout;
            analog_value <= next_analog;
            pulse_value  <= next_pulse;
            action_req   <= next_action;
            low_hit      <= next_low_hit;
        end
    end

endmodule

/* test/io_cond_sva.sv */
`timescale 1ns/1ps
module io_cond_sva (
    // Clock and enable
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               ce,
    // Bus handshakes
    input wire logic               awvalid,
    input wire logic               awready,
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [1:0]         bresp,
    input wire logic               arvalid,
    input wire logic               arready,
    input wire logic               rvalid,
    input wire logic               rready,
    input wire logic [31:0]        rdata,
    // Conditioned outputs
    input wire logic signed [11:0] analog_value,
    input wire logic signed [11:0] pulse_value,
    input wire logic [3:0]         dout,
    input wire logic [23:0]        action_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_analog_span;
        analog_value >= -12'sh3E8 && analog_value <= 12'sh3E8;
    endproperty
    a_analog_span: assert property (p_analog_span)
        else $error("analog value out of span");
    property p_pulse_span;
        pulse_value >= -12'sh3E8 && pulse_value <= 12'sh3E8;
    endproperty
    a_pulse_span: assert property (p_pulse_span)
        else $error("pulse value out of span");
    property p_wr_answer;
        awvalid && awready |=> bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered");
    property p_rd_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_b_stands;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_stands: assert property (p_b_stands)
        else $error("write response dropped early");
    property p_r_stands;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_stands: assert property (p_r_stands)
        else $error("read data dropped early");
    property p_b_done;
        bvalid && bready |=> !bvalid;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write response not cleared");
    property p_ce_gate;
        !ce |-> !awready && !arready;
    endproperty
    a_ce_gate: assert property (p_ce_gate)
        else $error("ready while disabled");
    property p_ce_freeze;
        !ce |=> $stable(pulse_value) && $stable(dout) && $stable(action_req);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("outputs moved while disabled");

    c_write: cover property (awvalid && awready);
    c_read: cover property (rvalid && rready);
    c_action: cover property (action_req != 24'h0);
endmodule

bind io_conditioning io_cond_sva u_sva (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .awvalid      (awvalid),
    .awready      (awready),
    .bvalid       (bvalid),
    .bready       (bready),
    .bresp        (bresp),
    .arvalid      (arvalid),
    .arready      (arready),
    .rvalid       (rvalid),
    .rready       (rready),
    .rdata        (rdata),
    .analog_value (analog_value),
    .pulse_value  (pulse_value),
    .dout         (dout),
    .action_req   (action_req)
);

/* test/io_field_model.sv */
`timescale 1ns/1ps
module io_field_model (
    // Clock
    input  wire logic        aclk,
    // Wanted levels
    input  wire logic [15:0] set_mv,
    input  wire logic [15:0] set_sup,
    input  wire logic [15:0] set_us,
    input  wire logic [3:0]  set_pin,
    // Lines into the block
    output logic      [15:0] analog_mv,
    output logic      [15:0] supply_mv,
    output logic      [15:0] pulse_us,
    output logic      [3:0]  din
);
    // Sensors settle one clock after being moved
    always_ff @(posedge aclk) begin
        analog_mv <= set_mv;
        supply_mv <= set_sup;
        pulse_us  <= set_us;
        din       <= set_pin;
    end
endmodule

/* test/io_input_conditioning_actions_tb.sv */
`timescale 1ns/1ps
module io_input_conditioning_actions_tb;
    import io_cond_pkg::*;
    logic               aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [5:0]         awaddr = '0, araddr = '0;
    logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0]        wdata = '0, rdata, rd_data;
    logic [1:0]         bresp, rresp, rd_resp, wr_resp;
    logic [15:0]        set_mv = 16'h09C4, set_sup = 16'h1388, set_us = 16'h05DC;
    logic [15:0]        analog_mv, supply_mv, pulse_us;
    logic [3:0]         set_pin = '0, din, dout;
    logic [2:0]         motor_on = '0, motor_rev = '0;
    logic               ovv = 1'h0, ovt = 1'h0, led = 1'h0, sw_fail = 1'h0;
    logic               awready, wready, arready, bvalid, rvalid;
    logic signed [11:0] analog_value, pulse_value;
    logic [23:0]        action_req;
    int                 error_cnt = 0, cmp_count = 0;
    localparam int      AMV[8] = '{2500, 4900, 100, 6000, 50, 1300, 3700, 2560};
    localparam int      AEX[8] = '{0, 1000, -1000, 1000, -1000, -500, 500, 0};

    always #50 aclk = ~aclk;

    io_field_model field (.aclk(aclk), .set_mv(set_mv), .set_sup(set_sup), .set_us(set_us),
        .set_pin(set_pin), .analog_mv(analog_mv), .supply_mv(supply_mv), .pulse_us(pulse_us), .din(din));
    io_conditioning dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .analog_mv(analog_mv),
        .supply_mv(supply_mv), .pulse_us(pulse_us), .din(din), .dout(dout), .motor_on(motor_on),
        .motor_reversed(motor_rev), .overvoltage(ovv), .overtemp(ovt), .status_led(led),
        .switch_fail(sw_fail), .analog_value(analog_value), .pulse_value(pulse_value),
        .action_req(action_req));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Response ready is raised a cycle late so the held answer is exercised
    task wr(input logic [5:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        do @(posedge aclk); while (!awready);
        awvalid <= 1'h0;
        wvalid  <= 1'h0;
        @(posedge aclk);
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        wr_resp = bresp;
        bready <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask
    task rd(input logic [5:0] a);
        araddr  <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        @(posedge aclk);
        rready <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'h0;
    endtask
    task settle;
        repeat (5) @(posedge aclk);
    endtask

    task t_defaults;
        rd(6'h04); chk(rd_data, 32'h64);
        rd(6'h08); chk(rd_data, 32'h9C4);
        rd(6'h0C); chk(rd_data, 32'h1324);
        rd(6'h10); chk(rd_data, 32'h5);
        rd(6'h28); chk(rd_data, 32'h5DC);
        rd(6'h2C); chk(rd_data, 32'h5);
        rd(6'h38); chk(rd_data, 32'h0); chk(32'(rd_resp), 32'h2);
        wr(6'h38, 32'h1); chk(32'(wr_resp), 32'h2);
    endtask
    task t_analog;
        wr(6'h00, 32'h101);
        for (int i = 0; i < 8; i++) begin
            set_mv <= 16'(AMV[i]); settle; chk(32'(analog_value), AEX[i]);
        end
        wr(6'h00, 32'h201); settle; chk(32'(analog_value), 32'd25);
        wr(6'h00, 32'h111); set_mv <= 16'hE74; settle; chk(32'(analog_value), -500);
        set_sup <= 16'hFA0; set_mv <= 16'hB90; wr(6'h00, 32'h102); settle;
        chk(32'(analog_value), 32'd500);
        wr(6'h04, 32'h1770); settle; chk(32'(analog_value), 32'h0);
        wr(6'h04, 32'h64); wr(6'h00, 32'h100); settle; chk(32'(analog_value), 32'h0);
    endtask
    task t_low;
        wr(6'h00, 32'h101); set_mv <= 16'h64; set_sup <= 16'h1388;
        for (int m = 1; m <= 3; m++) for (int c = 1; c <= 8; c++) begin
            wr(6'h14, 32'(m * 16 + c)); settle;
            chk(32'(action_req), 32'h1 << ((m - 1) * 8 + c - 1));
        end
        wr(6'h14, 32'h21); set_mv <= 16'h65; settle; chk(32'(action_req), 32'h0);
        set_mv <= 16'h64; settle; chk(32'(action_req), 32'h100);
        wr(6'h14, 32'h0); settle; chk(32'(action_req), 32'h0);
    endtask
    task t_din;
        wr(6'h20, 32'h22); set_pin <= 4'h1; settle; chk(32'(action_req), 32'h200);
        wr(6'h18, 32'h1); settle; chk(32'(action_req), 32'h0);
        set_pin <= 4'h0; settle; chk(32'(action_req), 32'h200);
        wr(6'h20, 32'h0); settle; chk(32'(action_req), 32'h0);
    endtask
    task t_dout;
        for (int s = 0; s <= 6; s++) begin
            wr(6'h24, 32'(16 + s));
            {motor_on, motor_rev, ovv, ovt, led, sw_fail} <= '1; settle;
            chk(32'(dout[0]), 32'(s inside {[1:5]}));
            {motor_on, motor_rev, ovv, ovt, led, sw_fail} <= '0; settle;
            chk(32'(dout[0]), 32'(s == 6));
        end
        wr(6'h1C, 32'h1); settle; chk(32'(dout[0]), 32'h0);
        wr(6'h24, 32'h0); settle; chk(32'(dout[0]), 32'h1);
    endtask
    task t_pulse;
        wr(6'h2C, 32'h105);
        set_us <= 16'h7D0; settle; chk(32'(pulse_value), 32'd1000);
        set_us <= 16'h6D6; settle; chk(32'(pulse_value), 32'd500);
        set_us <= 16'h5F0; settle; chk(32'(pulse_value), 32'h0);
        wr(6'h2C, 32'h205); settle; chk(32'(pulse_value), 32'd40);
        wr(6'h28, 32'h640); set_us <= 16'h640; settle; chk(32'(pulse_value), 32'h0);
        ce <= 1'h0; set_us <= 16'h7D0; settle; chk(32'(pulse_value), 32'h0);
        ce <= 1'h1; settle; chk(32'(pulse_value), 32'd1000);
        rd(6'h30); chk(rd_data, 32'h03E8_FC18);
        rd(6'h34); chk(rd_data, 32'h0001_0100);
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_defaults;
        t_analog;
        t_low;
        t_din;
        t_dout;
        t_pulse;
        print_verdict;
    end
endmodule
